// ---- gpp_pkg.sv ----
/*
  Shared constants and carrier types for the general purpose pin port.
  Assumes an APB master with 32-bit data and an 8-bit byte address.
*/
`default_nettype none

package gpp_pkg;

  // Pin group widths.
  localparam int GPI_W   = 22;
  localparam int GPO_W   = 24;
  localparam int GPIO_W  = 6;
  localparam int MEMIO_W = 13;
  localparam int IO_W    = GPIO_W + MEMIO_W;
  localparam int MUX_W   = GPO_W + GPIO_W;
  localparam int SYNC_W  = GPI_W + IO_W;

  // Register byte offsets.
  localparam logic [7:0] OFS_GPI_STATE  = 8'h00;
  localparam logic [7:0] OFS_GPO_SET    = 8'h04;
  localparam logic [7:0] OFS_GPO_CLR    = 8'h08;
  localparam logic [7:0] OFS_GPO_STATE  = 8'h0c;
  localparam logic [7:0] OFS_IO_DIR     = 8'h10;
  localparam logic [7:0] OFS_IO_SET     = 8'h14;
  localparam logic [7:0] OFS_IO_CLR     = 8'h18;
  localparam logic [7:0] OFS_IO_OUT     = 8'h1c;
  localparam logic [7:0] OFS_IO_PIN     = 8'h20;
  localparam logic [7:0] OFS_PIN_MUX    = 8'h24;
  localparam logic [7:0] OFS_MEM_CFG    = 8'h28;

  // Values after reset.
  localparam logic [GPO_W-1:0] GPO_RST    = 24'h000000;
  localparam logic [IO_W-1:0]  IO_OUT_RST = 19'h00000;
  localparam logic [IO_W-1:0]  IO_DIR_RST = 19'h00000;
  localparam logic [MUX_W-1:0] MUX_RST    = 30'h00000000;
  localparam logic             MEM16_RST  = 1'h0;
  localparam logic [SYNC_W-1:0] SYNC_RST  = 41'h00000000000;

  // Bit position of the first bidirectional pin's select in the mux register.
  localparam int MUX_IO_LSB = GPO_W;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } gpp_apb_req_s;

  typedef struct packed {
    logic [GPO_W-1:0] gpo_q;
    logic [IO_W-1:0]  io_out_q;
    logic [IO_W-1:0]  io_dir_q;
    logic [MUX_W-1:0] mux_q;
    logic             mem16_q;
    logic [31:0]      prdata_q;
    logic             err_q;
  } gpp_regs_s;

  typedef struct packed {
    logic [SYNC_W-1:0] stage1_q;
    logic [SYNC_W-1:0] stage2_q;
  } gpp_sync_s;

endpackage

`default_nettype wire

// ---- gpp_sync.sv ----
/*
  Two-stage synchroniser for the sampled pin levels.
  Assumes pins may change at any time relative to core_clk.
*/
`timescale 1ns/1ps
`default_nettype none

module gpp_sync
  import gpp_pkg::*;
(
  // Clock and reset.
  input  wire logic              core_clk,
  input  wire logic              sys_rst,
  input  wire logic              clk_en,
  // Levels.
  input  wire logic [SYNC_W-1:0] async_in,
  output logic      [SYNC_W-1:0] sync_out
);

  gpp_sync_s s_q;
  gpp_sync_s s_d;

  // The first stage feeds only the second stage, so a metastable value never fans out.
  always_comb begin
    s_d          = s_q;
    s_d.stage1_q = async_in;
    s_d.stage2_q = s_q.stage1_q;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s_q <= '{stage1_q: SYNC_RST, stage2_q: SYNC_RST};
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  assign sync_out = s_q.stage2_q;

endmodule // gpp_sync

`default_nettype wire

// ---- gpp_port.sv ----
/*
  General purpose pin port: input-only, output-only and bidirectional pins,
  set and clear strobes, direction and pin sharing control, APB register slave.
  Assumes synchronous pin outputs towards pads that resolve the enables, and a
  memory controller that owns the upper data lines while the bus is 32 bits wide.
*/
`timescale 1ns/1ps
`default_nettype none

module gpp_port
  import gpp_pkg::*;
(
  // Clock, reset and enable.
  input  wire logic               core_clk,
  input  wire logic               sys_rst,
  input  wire logic               clk_en,
  // APB slave.
  input  wire gpp_apb_req_s       apb_req,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  // Input-only and output-only pins.
  input  wire logic [GPI_W-1:0]   gpi_pin,
  output logic      [GPO_W-1:0]   gpo_pin,
  // Bidirectional pins: dedicated ones low, upper memory data lines high.
  input  wire logic [IO_W-1:0]    io_pin_in,
  output logic      [IO_W-1:0]    io_pin_out,
  output logic      [IO_W-1:0]    io_pin_oe_n,
  // Peripheral functions sharing the pins.
  input  wire logic [GPO_W-1:0]   periph_gpo_out,
  input  wire logic [GPIO_W-1:0]  periph_io_out,
  input  wire logic [GPIO_W-1:0]  periph_io_oe_n,
  output logic      [GPIO_W-1:0]  periph_io_in,
  // Memory controller upper data lines.
  input  wire logic [MEMIO_W-1:0] mem_dq_out,
  input  wire logic [MEMIO_W-1:0] mem_dq_oe_n,
  output logic      [MEMIO_W-1:0] mem_dq_in,
  output logic                    mem_bus16
);

  gpp_regs_s         r_q;
  gpp_regs_s         r_d;
  logic [SYNC_W-1:0] pins_sync;
  logic [GPI_W-1:0]  gpi_sync;
  logic [IO_W-1:0]   io_sync;
  logic              setup_ph;
  logic              wr_acc;

  // Applies a set or a clear mask; bits written as zero keep their value.
  function automatic logic [GPO_W-1:0] apply_mask(
    input logic [GPO_W-1:0] cur,
    input logic [GPO_W-1:0] mask,
    input logic             do_set,
    input logic             do_clr
  );
    logic [GPO_W-1:0] res;
    res = cur;
    if (do_set) begin
      res = cur | mask;
    end else if (do_clr) begin
      res = cur & ~mask;
    end
    return res;
  endfunction

  gpp_sync u_sync (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .clk_en   (clk_en),
    .async_in ({io_pin_in, gpi_pin}),
    .sync_out (pins_sync)
  );

  assign gpi_sync = pins_sync[GPI_W-1:0];
  assign io_sync  = pins_sync[SYNC_W-1:GPI_W];

  assign setup_ph = apb_req.psel & ~apb_req.penable;
  assign wr_acc   = apb_req.psel & apb_req.penable & apb_req.pwrite;

  always_comb begin
    logic [GPO_W-1:0] io_ext;
    io_ext = '0;
    r_d    = r_q;
    // Read data and error are prepared in the setup cycle so the access cycle answers at once.
    if (setup_ph) begin
      r_d.err_q    = 1'b0;
      r_d.prdata_q = 32'h00000000;
      case (apb_req.paddr)
        OFS_GPI_STATE: r_d.prdata_q = 32'(gpi_sync);
        OFS_GPO_SET,
        OFS_GPO_CLR,
        OFS_IO_SET,
        OFS_IO_CLR:    r_d.prdata_q = 32'h00000000;
        OFS_GPO_STATE: r_d.prdata_q = 32'(r_q.gpo_q);
        OFS_IO_DIR:    r_d.prdata_q = 32'(r_q.io_dir_q);
        OFS_IO_OUT:    r_d.prdata_q = 32'(r_q.io_out_q);
        OFS_IO_PIN:    r_d.prdata_q = 32'(io_sync);
        OFS_PIN_MUX:   r_d.prdata_q = 32'(r_q.mux_q);
        OFS_MEM_CFG:   r_d.prdata_q = 32'(r_q.mem16_q);
        default:       r_d.err_q    = 1'b1;
      endcase
    end
    if (wr_acc) begin
      // One write never carries both a set and a clear, so the two masks cannot collide.
      r_d.gpo_q = apply_mask(r_q.gpo_q, apb_req.pwdata[GPO_W-1:0],
                             apb_req.paddr == OFS_GPO_SET,
                             apb_req.paddr == OFS_GPO_CLR);
      io_ext    = apply_mask(GPO_W'(r_q.io_out_q), apb_req.pwdata[GPO_W-1:0],
                             apb_req.paddr == OFS_IO_SET,
                             apb_req.paddr == OFS_IO_CLR);
      r_d.io_out_q = io_ext[IO_W-1:0];
      if (apb_req.paddr == OFS_IO_DIR) begin
        r_d.io_dir_q = apb_req.pwdata[IO_W-1:0];
      end
      if (apb_req.paddr == OFS_PIN_MUX) begin
        r_d.mux_q = apb_req.pwdata[MUX_W-1:0];
      end
      if (apb_req.paddr == OFS_MEM_CFG) begin
        r_d.mem16_q = apb_req.pwdata[0];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      r_q <= '{gpo_q: GPO_RST, io_out_q: IO_OUT_RST, io_dir_q: IO_DIR_RST,
               mux_q: MUX_RST, mem16_q: MEM16_RST, prdata_q: 32'h00000000, err_q: 1'b0};
    end else if (clk_en) begin
      r_q <= r_d;
    end
  end

  // APB answers in the first access cycle; a frozen clock enable stalls the answer.
  assign pready  = clk_en;
  assign prdata  = r_q.prdata_q;
  assign pslverr = r_q.err_q & apb_req.psel & apb_req.penable;

  // Output-only pins: a set mux bit hands the pin to its peripheral.
  always_comb begin
    for (int i = 0; i < GPO_W; i++) begin
      gpo_pin[i] = r_q.mux_q[i] ? periph_gpo_out[i] : r_q.gpo_q[i];
    end
  end

  // Dedicated bidirectional pins: a direction bit of one drives the pin, unless a set mux bit hands direction and level to its peripheral.
  always_comb begin
    for (int i = 0; i < GPIO_W; i++) begin
      if (r_q.mux_q[MUX_IO_LSB+i]) begin
        io_pin_out[i]  = periph_io_out[i];
        io_pin_oe_n[i] = periph_io_oe_n[i];
      end else begin
        io_pin_out[i]  = r_q.io_out_q[i];
        io_pin_oe_n[i] = ~r_q.io_dir_q[i];
      end
    end
    // Upper memory data lines belong to the memory controller unless the bus is 16 bits.
    for (int j = GPIO_W; j < IO_W; j++) begin
      if (r_q.mem16_q) begin
        io_pin_out[j]  = r_q.io_out_q[j];
        io_pin_oe_n[j] = ~r_q.io_dir_q[j];
      end else begin
        io_pin_out[j]  = mem_dq_out[j-GPIO_W];
        io_pin_oe_n[j] = mem_dq_oe_n[j-GPIO_W];
      end
    end
  end

  // The memory controller has its own capture timing, so it sees the raw lines.
  assign periph_io_in = io_sync[GPIO_W-1:0];
  assign mem_dq_in    = io_pin_in[IO_W-1:GPIO_W];
  assign mem_bus16    = r_q.mem16_q;

endmodule // gpp_port

`default_nettype wire

// ---- gpp_port_assertions.sv ----
/* Checker for the pin port.
   Assumes it is bound to gpp_port and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module gpp_port_assertions
  import gpp_pkg::*;
(
  // Clock and reset.
  input wire logic               core_clk,
  input wire logic               sys_rst,
  input wire logic               clk_en,
  // Bus and pins.
  input wire gpp_apb_req_s       apb_req,
  input wire logic [31:0]        prdata,
  input wire logic               pready,
  input wire logic [GPO_W-1:0]   gpo_pin,
  input wire logic [GPO_W-1:0]   periph_gpo_out,
  input wire logic [IO_W-1:0]    io_pin_in,
  input wire logic [IO_W-1:0]    io_pin_oe_n,
  input wire logic [MEMIO_W-1:0] mem_dq_oe_n,
  input wire logic [GPIO_W-1:0]  periph_io_in,
  input wire logic               mem_bus16
);
  logic [MUX_W-1:0] mux_q;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  sequence s_wr(logic [7:0] a);
    apb_req.psel && apb_req.penable && pready && apb_req.pwrite && apb_req.paddr == a;
  endsequence
  sequence s_rd(logic [7:0] a);
    apb_req.psel && apb_req.penable && pready && !apb_req.pwrite && apb_req.paddr == a;
  endsequence
  // Shadow of the select register, so pins handed to peripherals are left out.
  always_ff @(posedge core_clk) begin
    if (sys_rst) mux_q <= MUX_RST;
    else if (apb_req.psel && apb_req.penable && pready && apb_req.pwrite && apb_req.paddr == OFS_PIN_MUX)
      mux_q <= apb_req.pwdata[MUX_W-1:0];
  end
  property p_set; s_wr(OFS_GPO_SET) |=> (gpo_pin | mux_q[23:0] | ~$past(apb_req.pwdata[23:0])) == '1; endproperty
  a_set: assert property (p_set) else $error("set left a pin low");
  property p_clr; s_wr(OFS_GPO_CLR) |=> (gpo_pin & ~mux_q[23:0] & $past(apb_req.pwdata[23:0])) == '0; endproperty
  a_clr: assert property (p_clr) else $error("clear left a pin high");
  property p_keep;
    (s_wr(OFS_GPO_SET) or s_wr(OFS_GPO_CLR))
      |=> ((gpo_pin ^ $past(gpo_pin)) & ~mux_q[23:0] & ~$past(apb_req.pwdata[23:0])) == '0;
  endproperty
  a_keep: assert property (p_keep) else $error("unselected pin moved");
  property p_dir;
    s_wr(OFS_IO_DIR) |=> (io_pin_oe_n[5:0] | mux_q[29:24]) == (~$past(apb_req.pwdata[5:0]) | mux_q[29:24]);
  endproperty
  a_dir: assert property (p_dir) else $error("direction not applied");
  property p_mem; !mem_bus16 |-> io_pin_oe_n[18:6] == mem_dq_oe_n; endproperty
  a_mem: assert property (p_mem) else $error("memory lines taken in wide mode");
  property p_mux; ((gpo_pin ^ periph_gpo_out) & mux_q[23:0]) == '0; endproperty
  a_mux: assert property (p_mux) else $error("shared pin not from peripheral");
  property p_sync; clk_en[*3] |-> periph_io_in == $past(io_pin_in[5:0], 2); endproperty
  a_sync: assert property (p_sync) else $error("input delay not two cycles");
  property p_rd; s_rd(OFS_GPO_STATE) |-> (prdata & ~{8'h00, mux_q[23:0]}) == {8'h00, gpo_pin & ~mux_q[23:0]}; endproperty
  a_rd: assert property (p_rd) else $error("output readback wrong");
  property p_pin; s_rd(OFS_IO_PIN) |-> prdata[5:0] == $past(periph_io_in); endproperty
  a_pin: assert property (p_pin) else $error("pin level readback wrong");
endmodule // gpp_port_assertions
`default_nettype wire

// ---- gpp_board.sv ----
/* Board model for the bidirectional pins.
   Assumes active-low enables from the port. */
`timescale 1ns/1ps
`default_nettype none
module gpp_board
  import gpp_pkg::*;
(
  // Pads.
  input  wire logic [IO_W-1:0] ext_val,
  input  wire logic [IO_W-1:0] io_pin_out,
  input  wire logic [IO_W-1:0] io_pin_oe_n,
  output logic      [IO_W-1:0] io_pin_in
);
  // Where the port releases a pin, the attached device drives its own level.
  assign io_pin_in = (io_pin_out & ~io_pin_oe_n) | (ext_val & io_pin_oe_n);
endmodule // gpp_board
`default_nettype wire

// ---- tb_top.sv ----
/* Self-checking bench for the pin port.
   Assumes an APB slave that answers through pready and the board model on the pads. */
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import gpp_pkg::*;
;
  logic             core_clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, pready, pslverr, mem16 = 1'b0;
  gpp_apb_req_s     req = '0;
  logic [31:0]      prdata, m;
  logic [GPI_W-1:0] gpi = '0;
  logic [GPO_W-1:0] gpo_pin, periph = '0, gpo = '0;
  logic [IO_W-1:0]  pin_out, oe_n, pin_in, ext = '0, io_out = '0, dir = '0, pv;
  logic [MUX_W-1:0]   mux = '0;
  logic [GPIO_W-1:0]  pio = '0, pio_oe_n = '1;
  logic [MEMIO_W-1:0] mdq = '0, mdq_oe_n = '1, mdq_in;
  logic               mbus16;
  logic [32:0]      exp_q[$];
  integer           seed = 33;
  int               fail_count = 0, comparisons = 0;
  gpp_port u_dut (.core_clk, .sys_rst, .clk_en, .apb_req(req), .prdata, .pready, .pslverr, .gpi_pin(gpi),
    .gpo_pin, .io_pin_in(pin_in), .io_pin_out(pin_out), .io_pin_oe_n(oe_n), .periph_gpo_out(periph),
    .periph_io_out(pio), .periph_io_oe_n(pio_oe_n), .periph_io_in(), .mem_dq_out(mdq),
    .mem_dq_oe_n(mdq_oe_n), .mem_dq_in(mdq_in), .mem_bus16(mbus16));
  gpp_board u_board (.ext_val(ext), .io_pin_out(pin_out), .io_pin_oe_n(oe_n), .io_pin_in(pin_in));
  initial forever #12.5 core_clk = ~core_clk;
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic cmp(input logic [32:0] g, input logic [32:0] e);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch at %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
    @(posedge core_clk);
    if (!w) exp_q.push_back(e);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge core_clk);
    req.penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask
  // Each pad follows its current owner: memory lines while the bus is wide, peripherals where selected.
  function automatic logic [IO_W-1:0] pins();
    logic [IO_W-1:0] d, v;
    d = dir;
    v = io_out;
    if (!mem16) begin
      d[18:6] = ~mdq_oe_n;
      v[18:6] = mdq;
    end
    for (int i = 0; i < GPIO_W; i++) if (mux[MUX_IO_LSB + i]) begin
      d[i] = ~pio_oe_n[i];
      v[i] = pio[i];
    end
    return (v & d) | (ext & ~d);
  endfunction
  always @(posedge core_clk)
    if (req.psel && req.penable && pready && !req.pwrite) cmp({pslverr, prdata}, exp_q.pop_front());
  // Far longer than the whole sequence, which needs well under a thousand cycles.
  initial begin
    repeat (4000) @(posedge core_clk);
    fail_count++;
    wrap_up();
  end
  initial begin
    repeat (6) @(posedge core_clk);
    sys_rst <= 1'b0;
    m = $random(seed);
    gpi <= m[21:0];
    m = $random(seed);
    mdq <= m[12:0];
    mdq_oe_n <= m[25:13];
    pio <= m[31:26];
    m = $random(seed);
    pio_oe_n <= m[5:0];
    for (int i = 1; i < 11; i++) if (i != 8) apb(1'b0, 8'(i * 4), 32'h0, 33'h0);
    apb(1'b0, OFS_GPI_STATE, 32'h0, 33'(gpi));
    repeat (24) begin
      m = $random(seed);
      apb(1'b1, m[31] ? OFS_GPO_SET : OFS_GPO_CLR, m, 33'h0);
      gpo = m[31] ? gpo | m[23:0] : gpo & ~m[23:0];
      apb(1'b1, m[30] ? OFS_IO_SET : OFS_IO_CLR, m, 33'h0);
      io_out = m[30] ? io_out | m[18:0] : io_out & ~m[18:0];
      apb(1'b0, OFS_GPO_STATE, 32'h0, 33'(gpo));
      apb(1'b0, OFS_IO_OUT, 32'h0, 33'(io_out));
    end
    m = $random(seed);
    ext <= m[18:0];
    m = $random(seed);
    dir = m[18:0];
    apb(1'b1, OFS_IO_DIR, m, 33'h0);
    apb(1'b0, OFS_IO_DIR, 32'h0, 33'(dir));
    apb(1'b0, OFS_IO_PIN, 32'h0, 33'(pins()));
    apb(1'b1, OFS_MEM_CFG, 32'h1, 33'h0);
    mem16 = 1'b1;
    apb(1'b0, OFS_MEM_CFG, 32'h0, 33'h1);
    apb(1'b0, OFS_IO_PIN, 32'h0, 33'(pins()));
    m = $random(seed);
    periph <= m[23:0];
    mux = m[29:0];
    apb(1'b1, OFS_PIN_MUX, m, 33'h0);
    apb(1'b0, OFS_PIN_MUX, 32'h0, 33'(mux));
    apb(1'b0, OFS_IO_PIN, 32'h0, 33'(pins()));
    @(negedge core_clk);
    pv = pins();
    cmp(33'(gpo_pin), 33'((periph & mux[23:0]) | (gpo & ~mux[23:0])));
    cmp(33'({mbus16, mdq_in}), 33'({mem16, pv[18:6]}));
    // The enable drops after the setup edge, so the access phase must wait for pready.
    fork
      apb(1'b0, OFS_GPO_STATE, 32'h0, 33'(gpo));
      begin
        repeat (2) @(posedge core_clk);
        clk_en <= 1'b0;
        repeat (3) @(posedge core_clk);
        clk_en <= 1'b1;
      end
    join
    apb(1'b0, 8'h40, 32'h0, {1'b1, 32'h0});
    @(posedge core_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    apb(1'b0, OFS_GPO_STATE, 32'h0, 33'h0);
    wrap_up();
  end
endmodule // tb_top
bind gpp_port gpp_port_assertions u_chk (.core_clk, .sys_rst, .clk_en, .apb_req, .prdata, .pready, .gpo_pin,
  .periph_gpo_out, .io_pin_in, .io_pin_oe_n, .mem_dq_oe_n, .periph_io_in, .mem_bus16);
`default_nettype wire
